/* include/rx_ctrl_pkg.sv */
// package for the receiver output control block
// assumes a classic wishbone slave with 32-bit data, 8-bit registers in low bits
package rx_ctrl_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] CFG1_INDEX = 8'h09;
   localparam logic [7:0] CFG2_INDEX = 8'h0a;
   localparam logic [7:0] STAT_INDEX = 8'h0b;
   localparam logic [7:0] CFG1_RESET = 8'h00;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   localparam int         SAMPLE_W   = 24;
   // soft mute: one bit of attenuation per sample
   localparam logic [4:0] SOFT_STEPS = 5'h18;

   // recovered clock ratio codes
   typedef enum logic [1:0] {
      RATIO_128 = 2'b00,
      RATIO_256 = 2'b01,
      RATIO_512 = 2'b10,
      RATIO_RSV = 2'b11
   } ratio_t;

   // parity/biphase error action codes
   typedef enum logic [1:0] {
      ERR_NONE = 2'b00,
      ERR_HOLD = 2'b01,
      ERR_ZERO = 2'b10,
      ERR_RSV  = 2'b11
   } err_act_t;

   // loss of lock action codes
   typedef enum logic [1:0] {
      LOCK_NONE = 2'b00,
      LOCK_HOLD = 2'b01,
      LOCK_ZERO = 2'b10,
      LOCK_SOFT = 2'b11
   } lock_act_t;

   // pll reference port codes
   typedef enum logic [1:0] {
      PORT_PLAYBACK = 2'b00,
      PORT_AUX_IN   = 2'b01,
      PORT_RECORD   = 2'b10,
      PORT_AUX_OUT  = 2'b11
   } ref_port_t;

   // register at 0x09
   typedef struct packed {
      logic      unlocked_clock_fallback;
      ratio_t    recovered_clock_ratio;
      logic      auto_deemphasis_enable;
      err_act_t  err_action;
      lock_act_t lock_action;
   } cfg1_t;

   // register at 0x0a
   typedef struct packed {
      logic      receiver_hard_mute;
      logic      port_reference_enable;
      ref_port_t reference_port_select;
      logic [1:0] reserved;
      logic      block_non_audio;
      logic      block_on_validity;
   } cfg2_t;

   // one received stereo sample with its flags
   typedef struct packed {
      logic [SAMPLE_W-1:0] data;
      logic                valid;      // strobe
      logic                bit_error;  // parity or biphase error
      logic                validity;   // validity flag of the subframe
      logic                compressed; // iec61937 payload
      logic                emphasis;   // channel status shows emphasis
   } rx_sample_t;
endpackage

/* src/rx_output_ctrl.sv */
// receiver output control: clock/reference selects, error and unlock handling,
// mute, de-emphasis request, gating toward the rate converter
// assumes clk_i 25 MHz, synchronous inputs, classic wishbone master
// What this block does
// R1: unlocked receiver clock fallback: pll or internal one
// R2: recovered clock ratio 128, 256, 512
// R3: auto de-emphasis follows channel status when enabled
// R4: bit error while pll locked: none, hold, or zero sample
// R5: unlock: none, hold, zeros, or soft mute
// R6: hard mute forces silence immediately
// R7: pll reference from preambles or serial port
// R8: two-bit code picks reference serial port
// R9: block non-audio bit stops data to converter
// R10: compressed payload never reaches converter
// R11: block on validity bit stops converter data
// R12: reserved ratio and error codes act as 00
`timescale 1ns/1ps
module rx_output_ctrl (
   input  wire logic                    clk_i,          // 25 MHz clock
   input  wire logic                    rst_i,          // sync reset, high
   input  wire logic [31:0]             wb_adr_i,       // byte address
   input  wire logic [31:0]             wb_dat_i,       // write data
   input  wire logic [3:0]              wb_sel_i,       // byte enables
   input  wire logic                    wb_we_i,        // write
   input  wire logic                    wb_cyc_i,       // cycle
   input  wire logic                    wb_stb_i,       // strobe
   output logic [31:0]                  wb_dat_o,       // read data
   output logic                         wb_ack_o,       // acknowledge
   output logic                         wb_err_o,       // unmapped access
   input  wire logic                    pll_locked_i,   // receiver pll lock
   input  wire rx_ctrl_pkg::rx_sample_t rx_i,           // decoded sample
   output logic [rx_ctrl_pkg::SAMPLE_W-1:0] audio_o,    // conditioned sample
   output logic                         audio_valid_o,  // sample strobe
   output logic                         src_valid_o,    // sample to converter
   output logic                         deemph_o,       // apply de-emphasis
   output logic                         clk_sel_internal_clock_one_o, // 1: internal clock one
   output logic [1:0]                   ratio_o,        // 00/01/10 = 128/256/512 fs
   output logic                         ref_port_en_o,  // 1: serial port reference
   output logic [1:0]                   ref_port_o      // reference port code
);
   localparam int W = rx_ctrl_pkg::SAMPLE_W;

   rx_ctrl_pkg::cfg1_t      cfg1_reg;
   rx_ctrl_pkg::cfg2_t      cfg2_reg;
   logic [W-1:0]            last_reg;
   logic [4:0]              soft_reg;
   logic                    unlocked;
   logic                    hit;
   logic [7:0]              idx;
   logic [W-1:0]            sample_next;
   rx_ctrl_pkg::err_act_t   err_eff;

   // reserved ratio code falls back to the 128 fs ratio
   function automatic logic [1:0] ratio_fix(input rx_ctrl_pkg::ratio_t r);
      if (r == rx_ctrl_pkg::RATIO_RSV) begin
         ratio_fix = rx_ctrl_pkg::RATIO_128; // R12
      end else begin
         ratio_fix = r; // R2
      end
   endfunction

   // reserved error code falls back to no action
   function automatic rx_ctrl_pkg::err_act_t err_fix(input rx_ctrl_pkg::err_act_t e);
      if (e == rx_ctrl_pkg::ERR_RSV) begin
         err_fix = rx_ctrl_pkg::ERR_NONE; // R12
      end else begin
         err_fix = e;
      end
   endfunction

   // sample may enter the rate converter: strobe and no gate active
   function automatic logic converter_pass(input rx_ctrl_pkg::rx_sample_t s,
                                           input rx_ctrl_pkg::cfg2_t     c);
      converter_pass = s.valid
                       && !c.block_non_audio    // R9
                       && !s.compressed         // R10
                       && !c.block_on_validity; // R11
   endfunction

   // register index from byte address
   assign idx      = wb_adr_i[9:2];
   assign hit      = (wb_adr_i[31:10] == 22'h00_0000) && (idx == rx_ctrl_pkg::CFG1_INDEX
                     || idx == rx_ctrl_pkg::CFG2_INDEX || idx == rx_ctrl_pkg::STAT_INDEX);
   assign unlocked = !pll_locked_i;

   // wishbone handshake: ack one cycle after request, dropped next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
         wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
      end
   end

   // register writes on the ack edge, byte lane zero only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg1_reg <= rx_ctrl_pkg::CFG1_RESET;
         cfg2_reg <= rx_ctrl_pkg::CFG2_RESET;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && hit) begin
         if (idx == rx_ctrl_pkg::CFG1_INDEX) begin
            cfg1_reg <= wb_dat_i[7:0];
         end
         if (idx == rx_ctrl_pkg::CFG2_INDEX) begin
            cfg2_reg <= {wb_dat_i[7:4], 2'b00, wb_dat_i[1:0]};
         end
      end
   end

   // read data, reserved bits zero; status shows lock and soft-mute progress
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         if (idx == rx_ctrl_pkg::CFG1_INDEX) begin
            wb_dat_o <= {24'h00_0000, cfg1_reg};
         end else if (idx == rx_ctrl_pkg::CFG2_INDEX) begin
            wb_dat_o <= {24'h00_0000, cfg2_reg};
         end else if (idx == rx_ctrl_pkg::STAT_INDEX) begin
            wb_dat_o <= {24'h00_0000, soft_reg, src_valid_o, audio_valid_o, pll_locked_i};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // clock and reference selects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_sel_internal_clock_one_o <= 1'b0;
         ratio_o         <= 2'b00;
         ref_port_en_o   <= 1'b0;
         ref_port_o      <= 2'b00;
      end else begin
         clk_sel_internal_clock_one_o <= unlocked && cfg1_reg.unlocked_clock_fallback; // R1
         ratio_o         <= ratio_fix(cfg1_reg.recovered_clock_ratio); // R2 R12
         ref_port_en_o   <= cfg2_reg.port_reference_enable; // R7
         ref_port_o      <= cfg2_reg.reference_port_select; // R8
      end
   end

   // reserved error code behaves as no action
   assign err_eff = err_fix(cfg1_reg.err_action); // R12

   // sample substitution: unlock action while unlocked, otherwise bit error action
   always_comb begin
      sample_next = rx_i.data;
      if (unlocked) begin
         unique case (cfg1_reg.lock_action)
            rx_ctrl_pkg::LOCK_NONE: sample_next = rx_i.data;
            rx_ctrl_pkg::LOCK_HOLD: sample_next = last_reg; // R5
            rx_ctrl_pkg::LOCK_ZERO: sample_next = '0; // R5
            rx_ctrl_pkg::LOCK_SOFT: sample_next = W'($signed(last_reg) >>> soft_reg); // R5
         endcase
      end else if (rx_i.bit_error) begin
         unique case (err_eff)
            rx_ctrl_pkg::ERR_HOLD: sample_next = last_reg; // R4
            rx_ctrl_pkg::ERR_ZERO: sample_next = '0; // R4
            default:               sample_next = rx_i.data; // R4
         endcase
      end
   end

   // last valid sample and soft-mute attenuation step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_reg <= '0;
         soft_reg <= 5'h00;
      end else if (rx_i.valid) begin
         if (!unlocked && !rx_i.bit_error) begin
            last_reg <= rx_i.data;
         end
         if (!unlocked) begin
            soft_reg <= 5'h00;
         end else if (soft_reg != rx_ctrl_pkg::SOFT_STEPS) begin
            soft_reg <= soft_reg + 5'h01; // R5
         end
      end
   end

   // output sample, mute, de-emphasis and converter gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         audio_o       <= '0;
         audio_valid_o <= 1'b0;
         src_valid_o   <= 1'b0;
         deemph_o      <= 1'b0;
      end else begin
         audio_valid_o <= rx_i.valid;
         if (cfg2_reg.receiver_hard_mute) begin
            audio_o <= '0; // R6
         end else if (rx_i.valid) begin
            audio_o <= sample_next;
         end
         deemph_o    <= cfg1_reg.auto_deemphasis_enable && rx_i.emphasis; // R3
         src_valid_o <= converter_pass(rx_i, cfg2_reg); // R9 R10 R11
      end
   end

   // checks
   AST_FALLBACK: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      ##1 (clk_sel_internal_clock_one_o == $past(!pll_locked_i && cfg1_reg.unlocked_clock_fallback)))
      else $error("fallback clock select wrong");
   AST_RATIO: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      ratio_o != 2'b11) else $error("reserved ratio driven");
   AST_DEEMPH: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      !cfg1_reg.auto_deemphasis_enable ##1 !$past(cfg1_reg.auto_deemphasis_enable)
      |-> !deemph_o) else $error("de-emphasis while disabled");
   AST_ERR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      rx_i.valid && rx_i.bit_error && pll_locked_i && cfg1_reg.err_action == 2'b10
      && !cfg2_reg.receiver_hard_mute |=> audio_o == '0) else $error("error not zeroed");
   AST_LOCK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      rx_i.valid && !pll_locked_i && cfg1_reg.lock_action == 2'b01
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(last_reg))
      else $error("unlock hold wrong");
   AST_MUTE: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      cfg2_reg.receiver_hard_mute |=> audio_o == '0) else $error("mute not silent");
   AST_REF: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      ##1 ref_port_o == $past(cfg2_reg.reference_port_select) && ref_port_en_o
      == $past(cfg2_reg.port_reference_enable)) else $error("reference select wrong");
   AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      rx_i.compressed || cfg2_reg.block_non_audio || cfg2_reg.block_on_validity
      |=> !src_valid_o) else $error("gated data reached converter");

   // bus answer checks
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

   AST_ERR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_err_o |=> !wb_err_o) else $error("err held two cycles");

   AST_ACK_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wb_ack_o && wb_err_o)) else $error("ack and err together");

   AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit |=> wb_ack_o)
      else $error("no ack for mapped access");

   AST_ERR_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit |=> wb_err_o && !wb_ack_o)
      else $error("no err for unmapped access");

   AST_READ_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("read upper bits set");

   // register contents
   AST_CFG2_RSV: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg2_reg.reserved == 2'b00) else $error("reserved bits stored");

   AST_RATIO_MAP: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      ##1 ratio_o == ratio_fix($past(cfg1_reg.recovered_clock_ratio)))
      else $error("ratio not copied");

   // output conditioning checks
   AST_FALLBACK_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      pll_locked_i |=> !clk_sel_internal_clock_one_o) else $error("fallback while locked");

   AST_DEEMPH_ON: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      cfg1_reg.auto_deemphasis_enable && rx_i.emphasis |=> deemph_o)
      else $error("de-emphasis not applied");

   AST_ERR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      rx_i.valid && rx_i.bit_error && pll_locked_i && cfg1_reg.err_action == 2'b01
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(last_reg)) else $error("error not held");

   AST_ERR_NONE: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      rx_i.valid && rx_i.bit_error && pll_locked_i && cfg1_reg.err_action == 2'b00
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(rx_i.data)) else $error("error acted");

   AST_ERR_RSV: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      rx_i.valid && rx_i.bit_error && pll_locked_i && cfg1_reg.err_action == 2'b11
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(rx_i.data)) else $error("reserved acted");

   AST_LOCK_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      rx_i.valid && !pll_locked_i && cfg1_reg.lock_action == 2'b10
      && !cfg2_reg.receiver_hard_mute |=> audio_o == '0) else $error("unlock not zeroed");

   AST_LOCK_NONE: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      rx_i.valid && !pll_locked_i && cfg1_reg.lock_action == 2'b00
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(rx_i.data)) else $error("unlock acted");

   AST_LOCK_SOFT: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      rx_i.valid && !pll_locked_i && cfg1_reg.lock_action == 2'b11 && soft_reg == 5'h00
      && !cfg2_reg.receiver_hard_mute |=> audio_o == $past(last_reg)) else $error("soft start wrong");

   AST_UNMUTED: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      !cfg2_reg.receiver_hard_mute && !rx_i.valid |=> $stable(audio_o))
      else $error("audio changed without strobe");

   AST_REF_EN: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      cfg2_reg.port_reference_enable |=> ref_port_en_o) else $error("port reference off");

   AST_NONAUDIO_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      cfg2_reg.block_non_audio |=> !src_valid_o) else $error("non-audio gate open");

   AST_PASS: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      rx_i.valid && !rx_i.compressed && !cfg2_reg.block_non_audio
      && !cfg2_reg.block_on_validity |=> src_valid_o) else $error("audio kept from converter");

   AST_VALIDITY_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      cfg2_reg.block_on_validity |=> !src_valid_o) else $error("validity gate open");
endmodule

/* tb/rx_source.sv */
// far-side transmitter model: decoded sample strobes and pll lock level
// assumes the bench calls send and set_lock from its own sequence
`timescale 1ns/1ps
module rx_source (
   input  wire logic              clk_i,    // bench clock
   output rx_ctrl_pkg::rx_sample_t rx_o,    // decoded sample
   output logic                   locked_o  // pll lock level
);
   initial begin
      rx_o     = '0;
      locked_o = 1'b0;
   end
   // one-cycle strobe; data inverted outside the strobe so stale data never matches
   task automatic send(input logic [23:0] d, input logic [3:0] f);
      @(posedge clk_i);
      rx_o <= {d, 1'b1, f};
      @(posedge clk_i);
      rx_o <= {~d, 1'b0, f};
   endtask
   // lock changes just after an edge
   task automatic set_lock(input logic l);
      @(posedge clk_i);
      locked_o <= l;
   endtask
endmodule

/* tb/spdif_receiver_output_control_tb_top.sv */
// bench for the receiver output control block
// assumes rx_source as the far side and a classic wishbone master here
`timescale 1ns/1ps
module spdif_receiver_output_control_tb_top;
   logic                    clk_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic [31:0]             wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rdata;
   logic [3:0]              wb_sel_i = 4'h1;
   logic                    wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic                    wb_ack_o, wb_err_o, berr, pll_locked_i;
   rx_ctrl_pkg::rx_sample_t rx_i;
   logic [23:0]             audio_o;
   logic                    audio_valid_o, src_valid_o, deemph_o, clk_sel_internal_clock_one_o;
   logic                    ref_port_en_o;
   logic [1:0]              ratio_o, ref_port_o;
   int                      fail_count = 0;
   int                      n_compared = 0;
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   rx_output_ctrl i_rx_output_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .pll_locked_i(pll_locked_i), .rx_i(rx_i), .audio_o(audio_o),
      .audio_valid_o(audio_valid_o), .src_valid_o(src_valid_o), .deemph_o(deemph_o),
      .clk_sel_internal_clock_one_o(clk_sel_internal_clock_one_o), .ratio_o(ratio_o),
      .ref_port_en_o(ref_port_en_o), .ref_port_o(ref_port_o));
   rx_source i_rx_source (.clk_i(clk_i), .rx_o(rx_i), .locked_o(pll_locked_i));
   // verdict and end of run
   task automatic complete_run();
      $display("errors %0d compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask
   // one classic cycle, held until ack or err, then released
   task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      for (i = 0; i < 16; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      if (i == 16) begin
         $display("MISMATCH %0t bus answer timeout", $time);
         fail_count++;
         complete_run();
      end
      rdata = wb_dat_o;
      berr  = wb_err_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic smp(input logic [23:0] d, input logic [3:0] f);
      i_rx_source.send(d, f);
      #1;
   endtask
   task automatic lock(input logic l);
      i_rx_source.set_lock(l);
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic t_regs();
      wb(0, 32'h0000_0024, 0); chk(rdata[23:0], 0);
      wb(0, 32'h0000_0028, 0); chk(rdata[23:0], 0);
      wb(1, 32'h0000_0030, 32'h0000_005a); chk(berr, 1);
      wb(1, 32'h0000_0028, 32'h0000_00f3); wb(0, 32'h0000_0028, 0); chk(rdata[23:0], 'hf3);
      wb_sel_i <= 4'h0;
      wb(1, 32'h0000_0028, 32'h0000_0011);
      wb_sel_i <= 4'h1;
      wb(0, 32'h0000_0028, 0); chk(rdata[23:0], 'hf3);
      wb(1, 32'h0000_0028, 0);
   endtask
   task automatic t_sel();
      for (int c = 0; c < 4; c++) begin
         wb(1, 32'h0000_0024, c << 5); chk(ratio_o, (c == 3) ? 0 : c);
         wb(1, 32'h0000_0028, 'h40 | (c << 4)); chk({ref_port_en_o, ref_port_o}, 4 | c);
      end
      wb(1, 32'h0000_0028, 0); chk(ref_port_en_o, 0);
      wb(1, 32'h0000_0024, 'h80); lock(0); chk(clk_sel_internal_clock_one_o, 1);
      lock(1); chk(clk_sel_internal_clock_one_o, 0);
      wb(1, 32'h0000_0024, 0); lock(0); chk(clk_sel_internal_clock_one_o, 0);
      lock(1);
      wb(0, 32'h0000_002c, 0); chk(rdata[0], 1);
   endtask
   task automatic t_gate();
      logic [11:0] cs [5] = '{12'h000, 12'h020, 12'h002, 12'h014, 12'h004};
      logic [1:0]  ex [5] = '{2'b11, 2'b10, 2'b10, 2'b10, 2'b11};
      for (int i = 0; i < 5; i++) begin
         wb(1, 32'h0000_0028, cs[i][11:4]);
         smp(24'h12_3456, cs[i][3:0]);
         chk({audio_valid_o, src_valid_o}, ex[i]);
      end
      wb(1, 32'h0000_0028, 0);
   endtask
   task automatic t_err();
      logic [23:0] ex [4] = '{24'h65_4321, 24'h11_1111, 24'h00_0000, 24'h65_4321};
      for (int c = 0; c < 4; c++) begin
         wb(1, 32'h0000_0024, c << 2);
         smp(24'h11_1111, 0);
         smp(24'h65_4321, 4'h8);
         chk(audio_o, ex[c]);
      end
   endtask
   task automatic t_unlock();
      logic [23:0] ex [3] = '{24'h65_4321, 24'h40_0000, 24'h00_0000};
      for (int c = 0; c < 4; c++) begin
         wb(1, 32'h0000_0024, c);
         smp(24'h40_0000, 0);
         lock(0);
         smp(24'h65_4321, 0);
         if (c < 3) chk(audio_o, ex[c]);
         else begin
            chk(audio_o, 24'h40_0000);
            smp(24'h65_4321, 0);
            chk(audio_o, 24'h20_0000);
         end
         lock(1);
      end
   endtask
   task automatic t_mute();
      wb(1, 32'h0000_0024, 0);
      wb(1, 32'h0000_0028, 'h80); smp(24'h7f_0001, 0); chk(audio_o, 0);
      wb(1, 32'h0000_0028, 0); smp(24'h7f_0001, 0); chk(audio_o, 24'h7f_0001);
      wb(1, 32'h0000_0024, 'h10); smp(24'h00_0100, 1); chk(deemph_o, 1);
      wb(1, 32'h0000_0024, 0); smp(24'h00_0100, 1); chk(deemph_o, 0);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_sel();
      t_gate();
      t_err();
      t_unlock();
      t_mute();
      complete_run();
   end
endmodule
